//--- verilog/fpur_pkg.sv
// Package for the flash protection and user word register group.
package fpur_pkg;

  // ==========================================================================
  // Register byte offsets.
  // ==========================================================================
  localparam logic [11:0] FPUR_OFF_USER_ZERO  = 12'h1E0;
  localparam logic [11:0] FPUR_OFF_USER_ONE   = 12'h1E4;
  localparam logic [11:0] FPUR_OFF_READ_ONE   = 12'h204;
  localparam logic [11:0] FPUR_OFF_READ_TWO   = 12'h208;
  localparam logic [11:0] FPUR_OFF_READ_THREE = 12'h20C;
  localparam logic [11:0] FPUR_OFF_EXEC_ONE   = 12'h404;
  localparam logic [11:0] FPUR_OFF_COMMIT     = 12'h600;
  localparam logic [11:0] FPUR_OFF_STATUS     = 12'h604;

  // ==========================================================================
  // Field positions and values.
  // ==========================================================================
  localparam int          FPUR_WRITABLE_BIT  = 31;
  localparam int          FPUR_DATA_WIDTH    = 31;
  localparam int          FPUR_PROT_WORDS    = 4;
  localparam logic [31:0] FPUR_USER_BLANK    = 32'hFFFFFFFF;
  localparam logic [31:0] FPUR_PROT_SHIPPED  = 32'hFFFFFFFF;
  localparam logic [31:0] FPUR_PROT_ABSENT   = 32'h00000000;
  localparam logic [31:0] FPUR_COMMIT_KEY    = 32'h0000C0DE;
  localparam logic [1:0]  FPUR_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  FPUR_RESP_SLVERR   = 2'h2;

  // ==========================================================================
  // Types.
  // ==========================================================================
  typedef enum logic [2:0] {
    FPUR_PWR_LOAD,
    FPUR_PWR_RUN
  } fpur_phase_t;

  // Which protection words are backed by flash.
  typedef struct packed {
    logic [FPUR_PROT_WORDS-1:0] read_impl;
    logic                       exec_impl;
  } fpur_impl_t;

endpackage : fpur_pkg

//--- verilog/fpur_regs.sv
// Flash protection words and write-once user words behind AXI4-Lite.
`timescale 1ns/10ps
// Function
// R1: User words hold 31 non-volatile write-once bits.
// R2: Bit 31 writable flag kept by hardware.
// R3: Read protect words: one bit per block.
// R4: Exec protect words: one bit per block.
// R5: Protection loaded from store at power-on.
// R6: Shipped protection bits read as one.
// R7: Writes clear bits only, never set.
// R8: Cleared bits permanent only after commit.
// R9: Uncommitted clears restored by power-on reset.
// R10: Each word covers 64 KB; absent zero.
// R11: Written user word ignores further writes.
module fpur_regs
  import fpur_pkg::*;
#(
  // Bit n set when read protection word n is backed by flash.
  parameter logic [3:0] READ_IMPL = 4'h3,
  // Set when the execute protection word is backed by flash.
  parameter logic       EXEC_IMPL = 1'h1
) (
  // Clock and synchronous reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address, data and response channels.
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address and data channels.
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Protection words toward the flash access checker.
  output logic [127:0]     read_protect_words,
  output logic [31:0]      exec_protect_words
);

  // ==========================================================================
  // Storage.
  // ==========================================================================
  // Index 0 to 3 of the read set: word zero (not mapped here) and words one to three.
  // The nv_ copies model the store and survive aresetn; the vol_ copies are what
  // software reads and what the flash access checker enforces.
  logic [31:0] nv_read [FPUR_PROT_WORDS];
  logic [31:0] vol_read [FPUR_PROT_WORDS];
  logic [31:0] nv_exec;
  logic [31:0] vol_exec;
  logic [31:0] nv_user [2];
  logic [31:0] vol_user [2];
  // Power-on phase: one load cycle after reset, then normal running.
  fpur_phase_t phase;
  // Low only before the first clock edge, so the store starts blank exactly once.
  logic        nv_init = 1'b0;
  // Number of commits since the last reset, shown in the status word.
  logic [7:0]  commit_count;

  // Captured write request, held until its response is taken.
  logic [11:0] aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;
  // Decoded write and read strobes.
  logic        wr_fire;
  logic [31:0] wmask;
  logic        wr_hit;
  logic [31:0] rd_val;
  logic        rd_hit;
  logic        commit_req;

  // Write strobes expand to a bit mask.
  assign wmask   = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  // A write acts once address and data are both held and no response is pending.
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  // A commit is a write of the key word to the commit offset.
  assign commit_req = wr_fire && aw_addr == FPUR_OFF_COMMIT && w_data == FPUR_COMMIT_KEY;

  // ==========================================================================
  // Non-volatile store model: blank on first life, updated by commit or by a user word write.
  // ==========================================================================
  // The store changes only by a commit or by the single write of a user word, so an
  // uncommitted clear is lost at the next reset while a user word write is permanent.
  // Nothing is stored while reset is asserted, even if a write was pending.
  always_ff @(posedge aclk) begin
    if (!nv_init) begin
      // R6 shipped all ones
      nv_init <= 1'b1;
      nv_exec <= FPUR_PROT_SHIPPED;
      nv_user[0] <= FPUR_USER_BLANK;
      nv_user[1] <= FPUR_USER_BLANK;
      for (int i = 0; i < FPUR_PROT_WORDS; i++) begin
        nv_read[i] <= FPUR_PROT_SHIPPED;
      end
    end else if (aresetn && phase == FPUR_PWR_RUN) begin
      // R8 commit saves clears
      if (commit_req) begin
        nv_exec <= vol_exec;
        for (int i = 0; i < FPUR_PROT_WORDS; i++) begin
          nv_read[i] <= vol_read[i];
        end
      end
      // R1 user word non-volatile
      // The word goes straight to the store: it is written once for the life of the part.
      for (int u = 0; u < 2; u++) begin
        if (wr_fire && aw_addr == (u == 0 ? FPUR_OFF_USER_ZERO : FPUR_OFF_USER_ONE)
            && nv_user[u][FPUR_WRITABLE_BIT]) begin
          nv_user[u] <= {1'b0, w_data[FPUR_DATA_WIDTH-1:0]};
        end
      end
    end
  end

  // ==========================================================================
  // Power-on phase and commit counter.
  // ==========================================================================
  // Reset holds the load phase; the first edge after release loads the volatile
  // copies, and the bus refuses requests until the phase has moved on.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase        <= FPUR_PWR_LOAD;
      commit_count <= 8'h00;
    end else begin
      phase <= FPUR_PWR_RUN;
      if (commit_req) begin
        commit_count <= commit_count + 8'h01;
      end
    end
  end

  // ==========================================================================
  // Volatile copies loaded at power-on, cleared by writes.
  // ==========================================================================
  // Protection bits only ever fall here; a rise is possible only through a reset
  // that reloads a value from the store.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vol_exec <= FPUR_PROT_ABSENT;
      for (int i = 0; i < FPUR_PROT_WORDS; i++) begin
        vol_read[i] <= FPUR_PROT_ABSENT;
      end
      vol_user[0] <= FPUR_USER_BLANK;
      vol_user[1] <= FPUR_USER_BLANK;
    end else if (phase == FPUR_PWR_LOAD) begin
      // R5 load from store
      // R9 restore uncommitted
      // R10 absent words zero
      // Absent words come up zero whatever the store holds for them.
      vol_exec <= EXEC_IMPL ? nv_exec : FPUR_PROT_ABSENT;
      for (int i = 0; i < FPUR_PROT_WORDS; i++) begin
        vol_read[i] <= READ_IMPL[i] ? nv_read[i] : FPUR_PROT_ABSENT;
      end
      vol_user[0] <= nv_user[0];
      vol_user[1] <= nv_user[1];
    end else if (wr_fire) begin
      // A zero data bit under an active strobe clears; a one leaves the bit alone.
      // R7 clear only
      // R3 read protect bits
      // R4 exec protect bits
      unique case (aw_addr)
        FPUR_OFF_READ_ONE:   vol_read[1] <= vol_read[1] & ~(~w_data & wmask);
        FPUR_OFF_READ_TWO:   vol_read[2] <= vol_read[2] & ~(~w_data & wmask);
        FPUR_OFF_READ_THREE: vol_read[3] <= vol_read[3] & ~(~w_data & wmask);
        FPUR_OFF_EXEC_ONE:   vol_exec    <= vol_exec    & ~(~w_data & wmask);
        // R2 writable flag cleared
        // R11 ignore after write
        // A user word takes data bits 30 to 0 with the flag bit cleared; strobes are ignored.
        FPUR_OFF_USER_ZERO: begin
          if (vol_user[0][FPUR_WRITABLE_BIT]) begin
            vol_user[0] <= {1'b0, w_data[FPUR_DATA_WIDTH-1:0]};
          end
        end
        FPUR_OFF_USER_ONE: begin
          if (vol_user[1][FPUR_WRITABLE_BIT]) begin
            vol_user[1] <= {1'b0, w_data[FPUR_DATA_WIDTH-1:0]};
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Protection outputs.
  // ==========================================================================
  // Registered copies toward the flash access checker, one cycle behind.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      read_protect_words <= '0;
      exec_protect_words <= '0;
    end else begin
      read_protect_words <= {vol_read[3], vol_read[2], vol_read[1], vol_read[0]};
      exec_protect_words <= vol_exec;
    end
  end

  // ==========================================================================
  // AXI4-Lite write channel.
  // ==========================================================================
  // Offsets that accept a write; any other offset answers with a slave error.
  always_comb begin
    unique case (aw_addr)
      FPUR_OFF_USER_ZERO, FPUR_OFF_USER_ONE, FPUR_OFF_READ_ONE, FPUR_OFF_READ_TWO,
      FPUR_OFF_READ_THREE, FPUR_OFF_EXEC_ONE, FPUR_OFF_COMMIT: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Address and data taken in either order, response after both.
  // Each ready pulses while its half is empty; dropping for a cycle between pulses
  // is allowed, since a master holds valid until it sees ready.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 12'h000;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= FPUR_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && phase == FPUR_PWR_RUN;
      s_axi_wready  <= !w_held && !s_axi_wready && phase == FPUR_PWR_RUN;
      // Address taken; every register is one word, so the low two bits are dropped.
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[11:2], 2'h0};
      end
      // Data and strobes taken.
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      // Response one edge after both halves are held; both are freed when it is taken.
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? FPUR_RESP_OKAY : FPUR_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel.
  // ==========================================================================
  // Read multiplexer; unmapped offsets read zero with a slave error.
  always_comb begin
    rd_hit = 1'b1;
    unique case ({s_axi_araddr[11:2], 2'h0})
      FPUR_OFF_USER_ZERO:  rd_val = vol_user[0];
      FPUR_OFF_USER_ONE:   rd_val = vol_user[1];
      FPUR_OFF_READ_ONE:   rd_val = vol_read[1];
      FPUR_OFF_READ_TWO:   rd_val = vol_read[2];
      FPUR_OFF_READ_THREE: rd_val = vol_read[3];
      FPUR_OFF_EXEC_ONE:   rd_val = vol_exec;
      FPUR_OFF_STATUS:     rd_val = {24'h000000, commit_count};
      default: begin
        rd_val = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // One read at a time; data held until taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= FPUR_RESP_OKAY;
    end else begin
      // Ready rises for one cycle once a request waits and no read data is pending.
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid
                       && phase == FPUR_PWR_RUN;
      // Data and status captured at the handshake and held until the master takes them.
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_hit ? FPUR_RESP_OKAY : FPUR_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : fpur_regs

//--- verification/fpur_regs_sva.sv
// Port checker for the flash protection and user word register group.
`timescale 1ns/10ps
module fpur_regs_sva
  import fpur_pkg::*;
#(
  parameter logic [3:0] READ_IMPL = 4'h3,
  parameter logic       EXEC_IMPL = 1'h1
) (
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire logic [11:0]  s_axi_awaddr,
  input wire logic         s_axi_awvalid,
  input wire logic         s_axi_awready,
  input wire logic         s_axi_wvalid,
  input wire logic         s_axi_wready,
  input wire logic [1:0]   s_axi_bresp,
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_bready,
  input wire logic [11:0]  s_axi_araddr,
  input wire logic         s_axi_arvalid,
  input wire logic         s_axi_arready,
  input wire logic [31:0]  s_axi_rdata,
  input wire logic [1:0]   s_axi_rresp,
  input wire logic         s_axi_rvalid,
  input wire logic         s_axi_rready,
  input wire logic [127:0] read_protect_words,
  input wire logic [31:0]  exec_protect_words
);
  // ==============================
  // Helper logic
  // ==============================
  logic [2:0] settle;
  // Counts edges after reset release so the power-on load is not seen as a set.
  always_ff @(posedge aclk) begin
    if (!aresetn) settle <= 3'h0;
    else if (settle != 3'h4) settle <= settle + 3'h1;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==============================
  // Assertions
  // ==============================
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("Write response dropped early.");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("Read data dropped early.");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("Read answer late.");
  property p_wr_answer;
    s_axi_wvalid && s_axi_wready && s_axi_awvalid && s_axi_awready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("Write answer late.");
  property p_no_set;
    settle == 3'h4 |-> (read_protect_words & ~$past(read_protect_words)) == 128'h0
      && (exec_protect_words & ~$past(exec_protect_words)) == 32'h0;
  endproperty
  a_no_set: assert property (p_no_set) else $error("Protection bit rose.");
  property p_absent;
    ((read_protect_words[127:96] & {32{~READ_IMPL[3]}}) | (exec_protect_words
      & {32{~EXEC_IMPL}}) | (read_protect_words[95:64] & {32{~READ_IMPL[2]}})) == 32'h0;
  endproperty
  a_absent: assert property (p_absent) else $error("Absent word not zero.");
  property p_rd_mirror;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == FPUR_OFF_READ_ONE
      |=> s_axi_rdata == read_protect_words[63:32];
  endproperty
  a_rd_mirror: assert property (p_rd_mirror) else $error("Read word mismatch.");
  property p_ex_mirror;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == FPUR_OFF_EXEC_ONE
      |=> s_axi_rdata == exec_protect_words;
  endproperty
  a_ex_mirror: assert property (p_ex_mirror) else $error("Exec word mismatch.");
endmodule : fpur_regs_sva
bind fpur_regs fpur_regs_sva #(.READ_IMPL(READ_IMPL), .EXEC_IMPL(EXEC_IMPL)) u_sva (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .read_protect_words, .exec_protect_words);

//--- verification/fpur_regs_bench.sv
// Self-checking bench for the flash protection and user word register group.
`timescale 1ns/10ps
module fpur_regs_bench;
  import fpur_pkg::*;
  // ==============================
  // Signals
  // ==============================
  logic         aclk = 1'b0, aresetn = 1'b0;
  logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0]  s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0]  s_axi_wdata = 32'h00000000, s_axi_rdata, exec_protect_words;
  logic [3:0]   s_axi_wstrb = 4'hF;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic [127:0] read_protect_words;
  int           error_cnt = 0, tests_run = 0;
  // Free-running 10 MHz clock.
  always #50 aclk = ~aclk;
  fpur_regs dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .read_protect_words, .exec_protect_words);
  // ==============================
  // Tasks
  // ==============================
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic hang(input string what);
    error_cnt++;
    $display("CHECK FAILED %s wait expected answer seen none", what);
    conclude();
  endtask : hang
  task automatic rst;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : rst
  // Lag is the number of edges before bready rises, so a response must stand meanwhile.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er,
                    input int lag = 0);
    int   n;
    logic done;
    @(posedge aclk);
    n = 0;
    done = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= (lag == 0);
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      done = s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1;
      if (!done && n >= lag && n < 40) s_axi_bready <= 1'b1;
    end while (!done && n < 40);
    s_axi_bready <= 1'b0;
    if (!done) hang("write");
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er,
                    input int lag = 0);
    int   n;
    logic done;
    @(posedge aclk);
    n = 0;
    done = 1'b0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= (lag == 0);
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      done = s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1;
      if (!done && n >= lag && n < 40) s_axi_rready <= 1'b1;
    end while (!done && n < 40);
    s_axi_rready <= 1'b0;
    if (!done) hang("read");
    chk("rdata", exp, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask : rd
  // ==============================
  // Sequence
  // ==============================
  // Runs the register scenarios in order, then reports.
  initial begin
    rst();
    rd(FPUR_OFF_READ_ONE, FPUR_PROT_SHIPPED, FPUR_RESP_OKAY);
    rd(FPUR_OFF_READ_TWO, FPUR_PROT_ABSENT, FPUR_RESP_OKAY);
    rd(FPUR_OFF_READ_THREE, FPUR_PROT_ABSENT, FPUR_RESP_OKAY);
    rd(FPUR_OFF_EXEC_ONE, FPUR_PROT_SHIPPED, FPUR_RESP_OKAY);
    rd(FPUR_OFF_USER_ZERO, FPUR_USER_BLANK, FPUR_RESP_OKAY);
    wr(FPUR_OFF_READ_ONE, 32'hFFFF00FF, FPUR_RESP_OKAY);
    wr(FPUR_OFF_READ_ONE, 32'hFFFFFFFF, FPUR_RESP_OKAY, 6);
    rd(FPUR_OFF_READ_ONE, 32'hFFFF00FF, FPUR_RESP_OKAY, 5);
    chk("read_word_one", 32'hFFFF00FF, read_protect_words[63:32]);
    chk("read_word_zero", FPUR_PROT_SHIPPED, read_protect_words[31:0]);
    wr(FPUR_OFF_READ_TWO, 32'hFFFFFFFF, FPUR_RESP_OKAY);
    rd(FPUR_OFF_READ_TWO, FPUR_PROT_ABSENT, FPUR_RESP_OKAY);
    wr(FPUR_OFF_USER_ZERO, 32'h12345678, FPUR_RESP_OKAY);
    rd(FPUR_OFF_USER_ZERO, 32'h12345678, FPUR_RESP_OKAY);
    wr(FPUR_OFF_USER_ZERO, 32'h00000001, FPUR_RESP_OKAY);
    rd(FPUR_OFF_USER_ZERO, 32'h12345678, FPUR_RESP_OKAY);
    wr(FPUR_OFF_USER_ONE, 32'hFFFFFFFF, FPUR_RESP_OKAY);
    rd(FPUR_OFF_USER_ONE, 32'h7FFFFFFF, FPUR_RESP_OKAY);
    wr(12'h100, 32'h00000000, FPUR_RESP_SLVERR);
    rd(12'h100, 32'h00000000, FPUR_RESP_SLVERR);
    rst();
    rd(FPUR_OFF_READ_ONE, FPUR_PROT_SHIPPED, FPUR_RESP_OKAY);
    rd(FPUR_OFF_USER_ZERO, 32'h12345678, FPUR_RESP_OKAY);
    wr(FPUR_OFF_EXEC_ONE, 32'h0000FFFF, FPUR_RESP_OKAY);
    wr(FPUR_OFF_COMMIT, FPUR_COMMIT_KEY, FPUR_RESP_OKAY);
    rd(FPUR_OFF_STATUS, 32'h00000001, FPUR_RESP_OKAY);
    rst();
    rd(FPUR_OFF_EXEC_ONE, 32'h0000FFFF, FPUR_RESP_OKAY);
    chk("exec_word_one", 32'h0000FFFF, exec_protect_words);
    conclude();
  end
endmodule : fpur_regs_bench
